// ==== core/serial_cmd_cfg.svh ====
// Constants of the serial command front end: codes, defaults, fields and timing
`ifndef SERIAL_CMD_CFG_SVH
`define SERIAL_CMD_CFG_SVH

// ****************************************************************
// Frame and timing
// ****************************************************************
`define CMD_BITS             16
`define CLOCK_FREQ_HZ        40000000
`define POR_TIMEOUT_MS       100
`define MIN_SCK_PHASE_CYC    2

// ****************************************************************
// Command codes (match value, mask of code bits)
// ****************************************************************
`define CODE_CONFIG          16'h8000
`define MASK_CONFIG          16'hff00
`define CODE_POWER           16'h8200
`define MASK_POWER           16'hff00
`define CODE_FREQ            16'ha000
`define MASK_FREQ            16'hf000
`define CODE_RATE            16'hc600
`define MASK_RATE            16'hff00
`define CODE_RX_CTRL         16'h9000
`define MASK_RX_CTRL         16'hf800
`define CODE_FILTER          16'hc200
`define MASK_FILTER          16'hff00
`define CODE_FIFO_MODE       16'hca00
`define MASK_FIFO_MODE       16'hff00
`define CODE_SYNC            16'hce00
`define MASK_SYNC            16'hff00
`define CODE_AFC             16'hc400
`define MASK_AFC             16'hff00
`define CODE_TX_CFG          16'h9800
`define MASK_TX_CFG          16'hf800
`define CODE_PLL             16'hcc00
`define MASK_PLL             16'hff00
`define CODE_WAKE            16'he000
`define MASK_WAKE            16'he000
`define CODE_DUTY            16'hc800
`define MASK_DUTY            16'hff00
`define CODE_LBD             16'hc000
`define MASK_LBD             16'hff00
`define CODE_RX_READ         16'hb000
`define MASK_RX_READ         16'hff00
`define CODE_TX_WRITE        16'hb800
`define MASK_TX_WRITE        16'hff00
`define CODE_STATUS          16'h0000
`define MASK_STATUS          16'h8000

// ****************************************************************
// Power-on defaults of the stored command registers
// ****************************************************************
`define POR_CONFIG           16'h8008
`define POR_POWER            16'h8208
`define POR_FREQ             16'ha680
`define POR_RATE             16'hc623
`define POR_RX_CTRL          16'h9080
`define POR_FILTER           16'hc200
`define POR_FIFO_MODE        16'hca00
`define POR_SYNC             16'hce00
`define POR_AFC              16'hc400
`define POR_TX_CFG           16'h9800
`define POR_PLL              16'hcc00
`define POR_WAKE             16'he000
`define POR_DUTY             16'hc800
`define POR_LBD              16'hc000

// ****************************************************************
// Field positions and limits
// ****************************************************************
`define CFG_TX_REG_EN_BIT    7
`define CFG_FIFO_EN_BIT      6
`define PWR_LOW_SUPPLY_BIT   2
`define PWR_WAKE_EN_BIT      1
`define FREQ_MIN             12'h060
`define FREQ_MAX             12'hf3f

// Status word bit positions
`define ST_TX_READY_BIT      15
`define ST_POR_BIT           14
`define ST_FILL_BIT          13
`define ST_OVF_UNR_BIT       12
`define ST_WAKE_BIT          11
`define ST_EXT_BIT           10
`define ST_LOW_SUPPLY_BIT    9

`endif

// ==== core/serial_cmd_pkg.sv ====
// Types shared by the serial command front end
package serial_cmd_pkg;

  // Stored commands first, then the three action commands
  typedef enum int unsigned {
    cmd_config, cmd_power, cmd_freq, cmd_rate, cmd_rx_ctrl, cmd_filter, cmd_fifo_mode,
    cmd_sync, cmd_afc, cmd_tx_cfg, cmd_pll, cmd_wake, cmd_duty, cmd_lbd,
    cmd_rx_read, cmd_tx_write, cmd_status
  } cmd_id_type;

  localparam int unsigned NUM_CMDS   = 17;
  localparam int unsigned NUM_STORED = 14;

  typedef enum logic [1:0] {
    st_por_wait, st_idle, st_shift, st_done
  } serial_state_type;

endpackage

// ==== core/pin_sync.sv ====
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned          WIDTH     = 1,
  parameter logic [WIDTH-1:0]     RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               rstn_i,
  // Pins and their synchronised copies
  input  wire logic [WIDTH-1:0]   async_i,
  output logic      [WIDTH-1:0]   sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      meta_q <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // pin_sync

// ==== core/serial_command_irq_front.sv ====
// Serial command front end with interrupt request logic
//
// What this block does
// R01 - While chip select is low, one data bit is taken per serial clock rise.
// R02 - Chip select high returns the serial interface to its idle state.
// R03 - Each frame is a command code then parameter bits; the code picks the function.
// R04 - Bits arrive most significant first and are assembled in that order.
// R05 - Don't-care bit positions never change device behaviour.
// R06 - Reset loads the default value into every command register.
// R07 - Commands are ignored during the power-on timeout.
// R08 - The power-on timeout lasts at most 100 ms.
// R09 - Any enabled event, power-on included, pulls the interrupt request low.
// R10 - Transmit-ready event when the holding register can take a byte.
// R11 - Fill-level event when the receive FIFO holds the programmed bit count.
// R12 - Error event on receive overflow or transmit underrun.
// R13 - Wake-up event when the wake timer expires.
// R14 - External event on a low-going pulse of the external interrupt pin.
// R15 - Low-supply event when supply drops below the programmed threshold.
// R16 - Fill-level and overflow events only while the receive FIFO is enabled.
// R17 - Transmit-ready and underrun events only while the holding register is enabled.
// R18 - Host reads status after the request line falls to find the source.
// R19 - A control bit at one activates its function, zero leaves it off.
// R20 - A receive read command shifts FIFO data out to the host.
// R21 - A transmit write command loads eight data bits into the holding register.
// R22 - A status read command shifts status and event flags out.
// R23 - All seventeen command types are recognised.
// R24 - A frame cut short by chip select changes no command register.
// R25 - Request stays low until status read clears the latched flags and the level conditions clear.
`timescale 1ns/100ps
`include "serial_cmd_cfg.svh"
module serial_command_irq_front #(
  parameter int unsigned POR_CYCLES =
    int'((64'(`POR_TIMEOUT_MS) * 64'(`CLOCK_FREQ_HZ)) / 64'd1000)
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Serial port pins
  input  wire logic        chip_select_n_i,
  input  wire logic        serial_clock_i,
  input  wire logic        serial_data_in_i,
  output logic             serial_data_out_o,
  // Interrupt pins
  input  wire logic        external_interrupt_in_n_i,
  output logic             interrupt_request_n_o,
  // Event sources from the transceiver core
  input  wire logic        tx_holding_ready_event_i,
  input  wire logic        rx_fill_level_event_i,
  input  wire logic        rx_overflow_event_i,
  input  wire logic        tx_underrun_event_i,
  input  wire logic        wake_timer_expiry_event_i,
  input  wire logic        low_supply_event_i,
  // Receive FIFO and transmit holding register
  input  wire logic [7:0]  rx_fifo_data_i,
  output logic             rx_fifo_pop_o,
  output logic [7:0]       tx_data_o,
  output logic             tx_write_o,
  // Command registers and readiness
  output logic [15:0]      command_reg_o [serial_cmd_pkg::NUM_STORED],
  output logic             commands_ready_o
);

  // ****************************************************************
  // Elaboration checks and constants
  // ****************************************************************
  localparam int unsigned PW = $clog2(POR_CYCLES + 1);

  if (POR_CYCLES < 1) begin : g_bad_por
    $error("POR_CYCLES must be at least one");
  end

  localparam logic [15:0] CODES [serial_cmd_pkg::NUM_CMDS] = '{
    `CODE_CONFIG, `CODE_POWER, `CODE_FREQ, `CODE_RATE, `CODE_RX_CTRL, `CODE_FILTER,
    `CODE_FIFO_MODE, `CODE_SYNC, `CODE_AFC, `CODE_TX_CFG, `CODE_PLL, `CODE_WAKE,
    `CODE_DUTY, `CODE_LBD, `CODE_RX_READ, `CODE_TX_WRITE, `CODE_STATUS};
  localparam logic [15:0] MASKS [serial_cmd_pkg::NUM_CMDS] = '{
    `MASK_CONFIG, `MASK_POWER, `MASK_FREQ, `MASK_RATE, `MASK_RX_CTRL, `MASK_FILTER,
    `MASK_FIFO_MODE, `MASK_SYNC, `MASK_AFC, `MASK_TX_CFG, `MASK_PLL, `MASK_WAKE,
    `MASK_DUTY, `MASK_LBD, `MASK_RX_READ, `MASK_TX_WRITE, `MASK_STATUS};
  localparam logic [15:0] DEFAULTS [serial_cmd_pkg::NUM_STORED] = '{
    `POR_CONFIG, `POR_POWER, `POR_FREQ, `POR_RATE, `POR_RX_CTRL, `POR_FILTER,
    `POR_FIFO_MODE, `POR_SYNC, `POR_AFC, `POR_TX_CFG, `POR_PLL, `POR_WAKE,
    `POR_DUTY, `POR_LBD};

  localparam int unsigned IX_RX_READ  = int'(serial_cmd_pkg::cmd_rx_read);
  localparam int unsigned IX_TX_WRITE = int'(serial_cmd_pkg::cmd_tx_write);
  localparam int unsigned IX_FREQ     = int'(serial_cmd_pkg::cmd_freq);
  localparam int unsigned IX_CONFIG   = int'(serial_cmd_pkg::cmd_config);
  localparam int unsigned IX_POWER    = int'(serial_cmd_pkg::cmd_power);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [3:0] pins_s;
  logic       cs_n_s;
  logic       sck_s;
  logic       sdi_s;
  logic       ext_n_s;
  logic       sck_prev_q;
  logic       ext_prev_q;
  logic       sck_rise;
  logic       sck_fall;
  logic       ext_pulse;

  pin_sync #(
    .WIDTH     (4),
    .RESET_VAL (4'h9)
  ) u_pin_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .async_i ({external_interrupt_in_n_i, serial_data_in_i, serial_clock_i,
               chip_select_n_i}),
    .sync_o  (pins_s)
  );

  assign cs_n_s  = pins_s[0];
  assign sck_s   = pins_s[1];
  assign sdi_s   = pins_s[2];
  assign ext_n_s = pins_s[3];

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      sck_prev_q <= 1'b0;
      ext_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      ext_prev_q <= ext_n_s;
    end
  end

  assign sck_rise  = sck_s & ~sck_prev_q;
  assign sck_fall  = ~sck_s & sck_prev_q;
  // Pulse counted at its trailing edge, once low then high again
  assign ext_pulse = ext_n_s & ~ext_prev_q; // R14

  // ****************************************************************
  // Power-on timeout
  // ****************************************************************
  logic [PW-1:0] por_cnt_q;
  logic          por_done;

  assign por_done = (por_cnt_q == PW'(POR_CYCLES));

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      por_cnt_q <= '0;
    end else if (!por_done) begin
      por_cnt_q <= por_cnt_q + PW'(1); // R08
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      commands_ready_o <= 1'b0;
    end else begin
      commands_ready_o <= por_done;
    end
  end

  // ****************************************************************
  // Serial frame state machine and shift register
  // ****************************************************************
  serial_cmd_pkg::serial_state_type state_q;
  logic [4:0]                      bit_cnt_q;
  logic [15:0]                     shift_q;
  logic [15:0]                     word_next;
  logic                            shifting;
  logic                            cmd_done;

  assign shifting  = (state_q == serial_cmd_pkg::st_shift);
  assign word_next = {shift_q[14:0], sdi_s}; // R04
  assign cmd_done  = shifting & sck_rise & (bit_cnt_q == 5'(`CMD_BITS - 1));

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_q <= serial_cmd_pkg::st_por_wait;
    end else begin
      unique case (state_q)
        serial_cmd_pkg::st_por_wait: begin
          if (por_done) begin
            state_q <= serial_cmd_pkg::st_idle; // R07
          end
        end
        serial_cmd_pkg::st_idle: begin
          if (!cs_n_s) begin
            state_q <= serial_cmd_pkg::st_shift;
          end
        end
        serial_cmd_pkg::st_shift: begin
          if (cs_n_s) begin
            state_q <= serial_cmd_pkg::st_idle; // R24
          end else if (cmd_done) begin
            state_q <= serial_cmd_pkg::st_done;
          end
        end
        serial_cmd_pkg::st_done: begin
          if (cs_n_s) begin
            state_q <= serial_cmd_pkg::st_idle; // R02
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i || cs_n_s) begin
      bit_cnt_q <= '0; // R02
      shift_q   <= '0;
    end else if (shifting && sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 5'd1; // R01
      shift_q   <= word_next;
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic [serial_cmd_pkg::NUM_CMDS-1:0] hit;
  logic [serial_cmd_pkg::NUM_CMDS-1:0] early_hit;
  logic                                freq_ok;
  logic                                rx_read_start;
  logic                                status_start;

  for (genvar i = 0; i < serial_cmd_pkg::NUM_CMDS; i++) begin : g_decode
    // Only the code bits take part in the match
    assign hit[i]       = ((word_next & MASKS[i]) == CODES[i]); // R03 R05 R23
    assign early_hit[i] = (({word_next[7:0], 8'h00} & MASKS[i]) == CODES[i]);
  end

  assign freq_ok = (word_next[11:0] >= `FREQ_MIN) && (word_next[11:0] <= `FREQ_MAX);
  assign rx_read_start = shifting & sck_rise & (bit_cnt_q == 5'd7) & early_hit[IX_RX_READ];
  assign status_start  = shifting & sck_rise & (bit_cnt_q == 5'd0) & ~sdi_s; // R22

  // ****************************************************************
  // Stored command registers
  // ****************************************************************
  logic [15:0] cmd_reg_q [serial_cmd_pkg::NUM_STORED];

  for (genvar i = 0; i < serial_cmd_pkg::NUM_STORED; i++) begin : g_regs
    always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
        cmd_reg_q[i] <= DEFAULTS[i]; // R06
      end else if (cmd_done && hit[i] && (i != IX_FREQ || freq_ok)) begin
        cmd_reg_q[i] <= word_next; // R24
      end
    end
    assign command_reg_o[i] = cmd_reg_q[i];
  end

  logic tx_reg_en;
  logic fifo_en;
  logic lbd_en;
  logic wake_en;

  // Each control bit enables its function when set
  assign tx_reg_en = cmd_reg_q[IX_CONFIG][`CFG_TX_REG_EN_BIT]; // R19
  assign fifo_en   = cmd_reg_q[IX_CONFIG][`CFG_FIFO_EN_BIT]; // R19
  assign lbd_en    = cmd_reg_q[IX_POWER][`PWR_LOW_SUPPLY_BIT];
  assign wake_en   = cmd_reg_q[IX_POWER][`PWR_WAKE_EN_BIT];

  // ****************************************************************
  // Transmit write and receive read actions
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      tx_data_o     <= 8'h00;
      tx_write_o    <= 1'b0;
      rx_fifo_pop_o <= 1'b0;
    end else begin
      tx_write_o    <= cmd_done & hit[IX_TX_WRITE]; // R21
      rx_fifo_pop_o <= cmd_done & hit[IX_RX_READ]; // R20
      if (cmd_done && hit[IX_TX_WRITE]) begin
        tx_data_o <= word_next[7:0]; // R21
      end
    end
  end

  // ****************************************************************
  // Event flags
  // ****************************************************************
  logic por_flag_q;
  logic ovf_unr_q;
  logic wake_q;
  logic ext_q;
  logic ovf_unr_set;
  logic tx_ready_lvl;
  logic fill_lvl;
  logic low_lvl;

  assign ovf_unr_set  = (rx_overflow_event_i & fifo_en) // R12 R16
                      | (tx_underrun_event_i & tx_reg_en); // R12 R17
  assign tx_ready_lvl = tx_holding_ready_event_i & tx_reg_en; // R10 R17
  assign fill_lvl     = rx_fill_level_event_i & fifo_en; // R11 R16
  assign low_lvl      = low_supply_event_i & lbd_en; // R15

  // A set arriving with the status-read clear is kept
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      por_flag_q <= 1'b1; // R09
      ovf_unr_q  <= 1'b0;
      wake_q     <= 1'b0;
      ext_q      <= 1'b0;
    end else begin
      por_flag_q <= por_flag_q & ~status_start; // R25
      ovf_unr_q  <= ovf_unr_set | (ovf_unr_q & ~status_start);
      wake_q     <= (wake_timer_expiry_event_i & wake_en) // R13
                  | (wake_q & ~status_start);
      ext_q      <= ext_pulse | (ext_q & ~status_start); // R14
    end
  end

  logic host_interrupt;

  assign host_interrupt = por_flag_q | ovf_unr_q | wake_q | ext_q
                        | tx_ready_lvl | fill_lvl | low_lvl;

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      interrupt_request_n_o <= 1'b0;
    end else begin
      interrupt_request_n_o <= ~host_interrupt; // R09 R25
    end
  end

  // ****************************************************************
  // Serial read-out register
  // ****************************************************************
  logic [15:0] status_word;
  logic [15:0] out_q;

  always_comb begin
    status_word                     = 16'h0000;
    status_word[`ST_TX_READY_BIT]   = tx_ready_lvl;
    status_word[`ST_POR_BIT]        = por_flag_q;
    status_word[`ST_FILL_BIT]       = fill_lvl;
    status_word[`ST_OVF_UNR_BIT]    = ovf_unr_q;
    status_word[`ST_WAKE_BIT]       = wake_q;
    status_word[`ST_EXT_BIT]        = ext_q;
    status_word[`ST_LOW_SUPPLY_BIT] = low_lvl;
  end

  // Loaded on a rise, presented from the next fall onward
  always_ff @(posedge clock_i) begin
    if (!rstn_i || cs_n_s) begin
      out_q <= 16'h0000;
    end else if (status_start) begin
      out_q <= status_word; // R22
    end else if (rx_read_start) begin
      out_q <= {rx_fifo_data_i, 8'h00}; // R20
    end else if (sck_fall && state_q != serial_cmd_pkg::st_idle) begin
      out_q <= {out_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      serial_data_out_o <= 1'b0;
    end else if (sck_fall || cs_n_s) begin
      serial_data_out_o <= out_q[15] & ~cs_n_s;
    end
  end

endmodule // serial_command_irq_front

// ==== tb/serial_command_irq_front_assertions.sv ====
// Port checker of the serial command front end
`timescale 1ns/100ps
module serial_command_irq_front_assertions #(
  parameter int unsigned POR_CYCLES = 20
) (
  // Clock, reset and inputs
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic        chip_select_n_i,
  input wire logic        tx_holding_ready_event_i,
  input wire logic        low_supply_event_i,
  // Outputs
  input wire logic        interrupt_request_n_o,
  input wire logic        rx_fifo_pop_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_write_o,
  input wire logic [15:0] command_reg_o [serial_cmd_pkg::NUM_STORED],
  input wire logic        commands_ready_o
);
  // *****
  // Cycles since reset release
  // *****
  logic [31:0] cnt_q;
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      cnt_q <= 32'h0;
    end else if (cnt_q != 32'hffffffff) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_sel_idle; chip_select_n_i [*6]; endsequence
  sequence s_low_on; (low_supply_event_i && command_reg_o[1][2]) [*4]; endsequence
  sequence s_tx_on; (tx_holding_ready_event_i && command_reg_o[0][7]) [*4]; endsequence

  property p_sel_idle; s_sel_idle |-> !tx_write_o && !rx_fifo_pop_o; endproperty
  property p_refuse; !commands_ready_o |=> $stable(command_reg_o[0]) && !tx_write_o; endproperty
  property p_por_early; cnt_q < POR_CYCLES - 1 |-> !commands_ready_o; endproperty
  property p_por_end; cnt_q > POR_CYCLES + 2 |-> commands_ready_o; endproperty
  property p_tx_one; tx_write_o |=> !tx_write_o; endproperty
  property p_tx_hold; !tx_write_o |-> $stable(tx_data_o); endproperty
  property p_one_func; !(tx_write_o && rx_fifo_pop_o); endproperty
  property p_por_irq; $rose(rstn_i) |-> !interrupt_request_n_o; endproperty
  property p_low_irq; s_low_on |-> !interrupt_request_n_o; endproperty
  property p_tx_irq; s_tx_on |-> !interrupt_request_n_o; endproperty

  a_sel_idle: assert property (p_sel_idle) else $error("pulse with select high");
  a_refuse: assert property (p_refuse) else $error("command taken too early");
  a_por_early: assert property (p_por_early) else $error("ready too early");
  a_por_end: assert property (p_por_end) else $error("ready too late");
  a_tx_one: assert property (p_tx_one) else $error("write pulse too long");
  a_tx_hold: assert property (p_tx_hold) else $error("tx data moved");
  a_one_func: assert property (p_one_func) else $error("two functions at once");
  a_por_irq: assert property (p_por_irq) else $error("no power-on request");
  a_low_irq: assert property (p_low_irq) else $error("no low-supply request");
  a_tx_irq: assert property (p_tx_irq) else $error("no tx-ready request");
endmodule // serial_command_irq_front_assertions

bind serial_command_irq_front serial_command_irq_front_assertions #(
  .POR_CYCLES (POR_CYCLES)
) i_checker (
  .clock_i, .rstn_i, .chip_select_n_i, .tx_holding_ready_event_i, .low_supply_event_i,
  .interrupt_request_n_o, .rx_fifo_pop_o, .tx_data_o, .tx_write_o, .command_reg_o,
  .commands_ready_o
);

// ==== tb/host_serial_master.sv ====
// Host model: serial bus master that frames and times commands
`timescale 1ns/100ps
module host_serial_master (
  // Clock
  input  wire logic clock_i,
  // Serial port
  output logic      chip_select_n_o,
  output logic      serial_clock_o,
  output logic      serial_data_o,
  input  wire logic serial_data_i
);
  initial begin
    chip_select_n_o = 1'b1;
    serial_clock_o = 1'b0;
    serial_data_o = 1'b0;
  end

  // *****
  // Frame of nbits, serial clock high for half clock cycles and low for half plus one
  // *****
  task automatic xfer(input logic [15:0] word, input int nbits, input int half,
                      output logic [15:0] rd);
    rd = 16'h0;
    @(posedge clock_i);
    #1 chip_select_n_o = 1'b0;
    repeat (2) @(posedge clock_i);
    for (int k = 0; k < nbits; k++) begin
      #1 serial_data_o = word[15-k];
      repeat (half) @(posedge clock_i);
      #1;
      if (k > 0) rd[16-k] = serial_data_i;
      serial_clock_o = 1'b1;
      repeat (half) @(posedge clock_i);
      #1 serial_clock_o = 1'b0;
      @(posedge clock_i);
    end
    repeat (half) @(posedge clock_i);
    #1 rd[0] = serial_data_i;
    chip_select_n_o = 1'b1;
    // Released data line shows the inverse of its last value
    serial_data_o = ~serial_data_o;
    repeat (half) @(posedge clock_i);
    #1;
  endtask
endmodule // host_serial_master

// ==== tb/tb_serial_command_irq_front.sv ====
// Self-checking bench of the serial command front end
`timescale 1ns/100ps
`include "serial_cmd_cfg.svh"
module tb_serial_command_irq_front;
  localparam int unsigned POR = 200;
  logic        clock_i;
  logic        rstn_i;
  logic        sel_n;
  logic        sck;
  logic        serial_data_in;
  logic        sdo;
  logic        irq_n;
  logic        pop;
  logic        tx_wr;
  logic        ready;
  logic        en;
  logic [6:0]  ev_q;
  logic [7:0]  fifo_byte;
  logic [7:0]  tx_data;
  logic [15:0] rd;
  logic [15:0] regs [serial_cmd_pkg::NUM_STORED];
  logic [15:0] exp_w [serial_cmd_pkg::NUM_STORED];
  logic [15:0] fw [3] = '{16'ha05f, 16'haf40, 16'ha060};
  int          st_bit [7] = '{15, 13, 12, 12, 11, 9, 10};
  logic [6:0]  lvl = 7'h23;
  int          bad_count = 0;
  int          total_checks = 0;
  int          pops = 0;
  int          writes = 0;

  serial_command_irq_front #(.POR_CYCLES(POR)) i_dut (
    .clock_i, .rstn_i, .chip_select_n_i(sel_n), .serial_clock_i(sck),
    .serial_data_in_i(serial_data_in), .serial_data_out_o(sdo),
    .external_interrupt_in_n_i(~ev_q[6]), .interrupt_request_n_o(irq_n),
    .tx_holding_ready_event_i(ev_q[0]), .rx_fill_level_event_i(ev_q[1]),
    .rx_overflow_event_i(ev_q[2]), .tx_underrun_event_i(ev_q[3]),
    .wake_timer_expiry_event_i(ev_q[4]), .low_supply_event_i(ev_q[5]),
    .rx_fifo_data_i(fifo_byte), .rx_fifo_pop_o(pop), .tx_data_o(tx_data),
    .tx_write_o(tx_wr), .command_reg_o(regs), .commands_ready_o(ready)
  );
  host_serial_master i_host (
    .clock_i, .chip_select_n_o(sel_n), .serial_clock_o(sck),
    .serial_data_o(serial_data_in), .serial_data_i(sdo)
  );

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (pop === 1'b1) pops++;
    if (tx_wr === 1'b1) writes++;
  end

  // *****
  // Access, compare and run end
  // *****
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic send(input logic [15:0] w, input int n = 16, input int half = 5);
    i_host.xfer(w, n, half, rd);
  endtask
  task automatic regs_ok();
    for (int i = 0; i < serial_cmd_pkg::NUM_STORED; i++)
      check("command word", exp_w[i], regs[i]);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clock_i);
    bad_count++;
    stop_test();
  end

  initial begin
    rstn_i = 1'b0;
    ev_q = 7'h0;
    fifo_byte = 8'h3c;
    exp_w = '{`POR_CONFIG, `POR_POWER, `POR_FREQ, `POR_RATE, `POR_RX_CTRL, `POR_FILTER,
      `POR_FIFO_MODE, `POR_SYNC, `POR_AFC, `POR_TX_CFG, `POR_PLL, `POR_WAKE, `POR_DUTY,
      `POR_LBD};
    tick(10);
    regs_ok();
    check("request at reset", 16'h0, {15'h0, irq_n});
    rstn_i = 1'b1;
    send(16'h80ff, 16, 3);
    check("config after early frame", `POR_CONFIG, regs[0]);
    for (int i = 0; i < 400 && ready !== 1'b1; i++) tick(1);
    check("ready", 16'h1, {15'h0, ready});
    send(16'h0000);
    check("status after reset", 16'h4000, rd);
    tick(4);
    check("request after status", 16'h1, {15'h0, irq_n});
    for (int i = 0; i < serial_cmd_pkg::NUM_STORED; i++) begin
      exp_w[i][7:0] = 8'ha5;
      send(exp_w[i]);
    end
    regs_ok();
    foreach (fw[i]) begin
      send(fw[i]);
      if (i == 2) exp_w[2] = fw[i];
      check("freq word", exp_w[2], regs[2]);
    end
    send(16'hb85a, 16, 3);
    check("tx data", 16'h005a, {8'h0, tx_data});
    check("tx writes", 16'h1, 16'(writes));
    send(16'hb000);
    // Byte is loaded on the 8th rise and leaves on the falls after it
    check("fifo frame", {7'h0, fifo_byte, 1'b0}, rd);
    check("fifo pops", 16'h1, 16'(pops));
    send(16'h80ff, 15);
    check("config after cut frame", exp_w[0], regs[0]);
    send(16'h8000);
    check("config after fresh frame", 16'h8000, regs[0]);
    // Events with every enable off, then with every enable on
    for (int p = 0; p < 2; p++) begin
      send(p ? 16'h80c0 : 16'h8000);
      send(p ? 16'h8206 : 16'h8200);
      for (int i = 0; i < 7; i++) begin
        en = (p == 1) || (i == 6);
        ev_q[i] = 1'b1;
        if (!lvl[i]) begin
          tick(i == 6 ? 3 : 1);
          ev_q[i] = 1'b0;
        end
        tick(8);
        check("request", {15'h0, !en}, {15'h0, irq_n});
        send(16'h0000);
        check("status", en ? 16'h1 << st_bit[i] : 16'h0, rd);
        ev_q[i] = 1'b0;
        tick(8);
        check("request released", 16'h1, {15'h0, irq_n});
      end
    end
    exp_w[0] = 16'h80c0;
    exp_w[1] = 16'h8206;
    regs_ok();
    stop_test();
  end
endmodule // tb_serial_command_irq_front
